// *** hw/tss_pkg.sv ***
// constants, types and register map of the touch scan timing sequencer
package tss_pkg;

  localparam int CLK_MHZ = 10;
  localparam int ADDR_W  = 4;
  localparam int DATA_W  = 32;
  localparam int DLY_W   = 24;
  localparam int RES_W   = 12;

  localparam logic [ADDR_W-1:0] ADDR_CFG0 = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CFG1 = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_DATA = 4'hc;

  // config register zero fields
  localparam int CFG0_DIV_LSB = 0;
  localparam int CFG0_PVS_LSB = 2;
  localparam int CFG0_PR_LSB  = 5;
  localparam int CFG0_SN_LSB  = 8;
  localparam int CFG0_W       = 11;
  // config register one fields
  localparam int CFG1_MODE_BIT  = 0;
  localparam int CFG1_SAMP_LSB  = 1;
  localparam int CFG1_BATCH_LSB = 4;
  localparam int CFG1_RES12_BIT = 7;
  localparam int CFG1_EN_BIT    = 8;
  localparam int CFG1_W         = 9;
  // status fields
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_COORD_LSB = 1;
  localparam int STAT_PEN_BIT   = 3;
  localparam int STAT_WARN_BIT  = 4;
  localparam int STAT_SETS_LSB  = 8;
  localparam int SETS_W         = 8;

  localparam logic [CFG0_W-1:0] CFG0_RST = 11'h001;
  localparam logic [CFG1_W-1:0] CFG1_RST = 9'h084;

  localparam logic [1:0] DIV_BY1 = 2'h0;
  localparam logic [1:0] DIV_BY2 = 2'h1;
  localparam logic [1:0] MAX_BY1 = 2'h0;
  localparam logic [1:0] MAX_BY2 = 2'h1;
  localparam logic [1:0] MAX_BY4 = 2'h3;

  // delay codes in microseconds
  localparam int PVS_US [8] = '{0, 1, 2, 5, 10, 50, 100, 500};
  localparam int PR_US  [8] = '{0, 1, 2, 4, 8, 16, 20, 32};
  localparam int SN_US  [8] = '{0, 2, 4, 8, 16, 32, 64, 128};
  localparam int BATCH_STEP_US = 1000;

  localparam int ACQ_TICKS = 1;
  localparam int BITS_LO   = 10;
  localparam int BITS_HI   = 12;

  localparam logic [1:0] TAG_Y  = 2'h0;
  localparam logic [1:0] TAG_X  = 2'h1;
  localparam logic [1:0] TAG_Z1 = 2'h2;
  localparam logic [1:0] TAG_Z2 = 2'h3;

  typedef enum {ST_IDLE, ST_DRIVE, ST_SAMPLE, ST_PRECHG, ST_SENSE, ST_BATCH} tss_state_e;
  typedef enum logic [1:0] {CO_Y, CO_X, CO_Z} tss_coord_e;

  typedef struct packed {
    logic yPlus;
    logic yMinus;
    logic xPlus;
    logic xMinus;
  } tss_drive_s;

  typedef struct packed {
    logic             valid;
    logic [1:0]       tag;
    logic [RES_W-1:0] value;
  } tss_sample_s;

endpackage

// *** hw/tss_sequencer.sv ***
// touch scan timing sequencer: panel drive, delays and converter pacing
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - state machines on oscillator, converter clock divided
// - twelve-bit needs divide by two or four
// - two-bit divide field picks 1, 2, 4
// - wait stabilisation delay after drivers on
// - stabilisation field lives in config register zero
// - Y converted first in every set
// - Y: Y-plus supply, Y-minus ground, samples
// - X: X-plus supply, X-minus ground, samples
// - pressure: Y-plus, X-minus, two sample groups
// - precharge then sense between coordinates
// - precharge interval length from its field
// - sense interval length from its field
// - drivers on in stabilisation and sampling, off otherwise
// - keep scanning sets while pen stays down
// - batch delay idles between sets
// - faster converter clock shortens acquisition
module tss_sequencer #(
  parameter int BATCH_STEP_CYC = tss_pkg::BATCH_STEP_US * tss_pkg::CLK_MHZ
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic [tss_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [tss_pkg::DATA_W-1:0]  regWdata,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [tss_pkg::DATA_W-1:0]  regRdata,
  input  wire logic                        penDownPin,
  input  wire logic [tss_pkg::RES_W-1:0]   adcResult,
  output logic                             adcClkEn,
  output logic                             adcStart,
  output tss_pkg::tss_drive_s              drive,
  output tss_pkg::tss_sample_s             sample
);
  import tss_pkg::*;

  if (BATCH_STEP_CYC < 1 || BATCH_STEP_CYC * 7 >= 2 ** DLY_W) begin : gChk
    $error("BATCH_STEP_CYC out of range");
  end

  if (CFG0_SN_LSB + 3 > CFG0_W || CFG1_EN_BIT >= CFG1_W) begin : gFieldChk
    $error("configuration fields overrun their registers");
  end

  if (STAT_SETS_LSB + SETS_W > DATA_W) begin : gStatChk
    $error("status word too narrow for the set counter");
  end

  if (RES_W > DATA_W) begin : gResChk
    $error("converter result wider than the read word");
  end

  if (BITS_HI + ACQ_TICKS > 15) begin : gTickChk
    $error("conversion length overruns the tick counter");
  end

  logic [CFG0_W-1:0] cfg0_r;
  logic [CFG1_W-1:0] cfg1_r;
  logic [DATA_W-1:0] rdata_r;
  logic              penMeta_r;
  logic              pen_r;
  logic [1:0]        divCnt_r;
  tss_state_e        state_r;
  tss_state_e        state_nxt;
  tss_coord_e        coord_r;
  tss_coord_e        coord_nxt;
  logic [DLY_W-1:0]  dly_r;
  logic [DLY_W-1:0]  dly_nxt;
  logic [3:0]        tick_r;
  logic [3:0]        tick_nxt;
  logic [4:0]        samp_r;
  logic [4:0]        samp_nxt;
  logic [SETS_W-1:0] sets_r;
  logic [RES_W-1:0]  last_r;
  tss_drive_s        drive_r;
  tss_drive_s        drive_nxt;
  tss_sample_s       sample_r;

  // configuration decode
  wire logic [1:0] divCode = cfg0_r[CFG0_DIV_LSB +: 2];
  wire logic [2:0] pvsCode = cfg0_r[CFG0_PVS_LSB +: 3];
  wire logic [2:0] prCode  = cfg0_r[CFG0_PR_LSB +: 3];
  wire logic [2:0] snCode  = cfg0_r[CFG0_SN_LSB +: 3];
  wire logic       modeZ   = cfg1_r[CFG1_MODE_BIT];
  wire logic [2:0] sampCode = cfg1_r[CFG1_SAMP_LSB +: 3];
  wire logic [2:0] batchCode = cfg1_r[CFG1_BATCH_LSB +: 3];
  wire logic       res12   = cfg1_r[CFG1_RES12_BIT];
  wire logic       enable  = cfg1_r[CFG1_EN_BIT];

  // twelve bits at the undivided clock is not accurate: run at half rate instead
  wire logic       resWarn = res12 && (divCode == DIV_BY1);
  wire logic [1:0] divEff  = resWarn ? DIV_BY2 : divCode;
  wire logic [1:0] divMax  = (divEff == DIV_BY1) ? MAX_BY1 :
                             (divEff == DIV_BY2) ? MAX_BY2 : MAX_BY4;
  wire logic       tick    = (divCnt_r == divMax);

  // conversion length counted in converter ticks, so it scales with the divider
  wire logic [3:0] convTicks = res12 ?
                               4'(BITS_HI + ACQ_TICKS) :
                               4'(BITS_LO + ACQ_TICKS);

  // code to cycle lookups
  wire logic [DLY_W-1:0] pvsCyc   = DLY_W'(PVS_US[pvsCode] * CLK_MHZ);
  wire logic [DLY_W-1:0] prCyc    = DLY_W'(PR_US[prCode] * CLK_MHZ);
  wire logic [DLY_W-1:0] snCyc    = DLY_W'(SN_US[snCode] * CLK_MHZ);
  wire logic [DLY_W-1:0] batchCyc = DLY_W'(int'(batchCode) * BATCH_STEP_CYC);

  // samples per coordinate; pressure takes both groups back to back
  wire logic [4:0] nSamp     = 5'(sampCode) + 5'h01;
  wire logic [4:0] totalSamp = (coord_r == CO_Z) ? 5'(nSamp << 1) : nSamp;
  wire logic       dlyDone   = (dly_r == '0);
  wire logic       convDone  = tick && (tick_r == convTicks - 4'h1);
  wire logic       lastSamp  = (samp_r == totalSamp - 5'h01);
  wire logic       lastCoord = modeZ ? (coord_r == CO_Z) : (coord_r == CO_X);
  // first group of the pressure coordinate is tagged Z1, the second Z2
  wire logic [1:0] curTag    = (coord_r == CO_Y) ? TAG_Y :
                               (coord_r == CO_X) ? TAG_X :
                               (samp_r < nSamp)  ? TAG_Z1 : TAG_Z2;
  wire logic       capture   = (state_r == ST_SAMPLE) && convDone;

  // register bus decode
  wire logic wrCfg0 = regWr && (regAddr == ADDR_CFG0);
  wire logic wrCfg1 = regWr && (regAddr == ADDR_CFG1);
  wire logic busy   = (state_r != ST_IDLE);
  wire logic [DATA_W-1:0] statWord = {
    16'h0000,
    sets_r,
    3'h0,
    resWarn,
    pen_r,
    2'(coord_r),
    busy
  };
  // read data stands one cycle after the strobe, zero otherwise
  wire logic [DATA_W-1:0] rdSel =
    (regAddr == ADDR_CFG0) ? DATA_W'(cfg0_r) :
    (regAddr == ADDR_CFG1) ? DATA_W'(cfg1_r) :
    (regAddr == ADDR_STAT) ? statWord :
    (regAddr == ADDR_DATA) ? DATA_W'(last_r) : '0;

  // sequencing
  always_comb begin
    state_nxt = state_r;
    coord_nxt = coord_r;
    dly_nxt   = dly_r;
    tick_nxt  = tick_r;
    samp_nxt  = samp_r;
    unique case (state_r)
      ST_IDLE: begin
        if (enable && pen_r) begin
          state_nxt = ST_DRIVE;
          coord_nxt = CO_Y;
          dly_nxt   = pvsCyc;
        end
      end
      ST_DRIVE: begin
        if (dlyDone) begin
          state_nxt = ST_SAMPLE;
          tick_nxt  = '0;
          samp_nxt  = '0;
        end else begin
          dly_nxt = dly_r - DLY_W'(1);
        end
      end
      ST_SAMPLE: begin
        if (tick) begin
          tick_nxt = convDone ? 4'h0 : tick_r + 4'h1;
        end
        if (convDone) begin
          samp_nxt = samp_r + 5'h01;
          if (lastSamp) begin
            state_nxt = ST_PRECHG;
            dly_nxt   = prCyc;
          end
        end
      end
      ST_PRECHG: begin
        if (dlyDone) begin
          state_nxt = ST_SENSE;
          dly_nxt   = snCyc;
        end else begin
          dly_nxt = dly_r - DLY_W'(1);
        end
      end
      ST_SENSE: begin
        if (!dlyDone) begin
          dly_nxt = dly_r - DLY_W'(1);
        end else if (lastCoord) begin
          state_nxt = ST_BATCH;
          dly_nxt   = batchCyc;
        end else begin
          state_nxt = ST_DRIVE;
          coord_nxt = (coord_r == CO_Y) ? CO_X : CO_Z;
          dly_nxt   = pvsCyc;
        end
      end
      ST_BATCH: begin
        if (dlyDone) begin
          state_nxt = ST_IDLE;
        end else begin
          dly_nxt = dly_r - DLY_W'(1);
        end
      end
    endcase
  end

  // panel drive follows the next state; off in precharge, sense and idle phases
  always_comb begin
    drive_nxt = '0;
    if (state_nxt == ST_DRIVE || state_nxt == ST_SAMPLE) begin
      unique case (coord_nxt)
        CO_Y: begin
          drive_nxt.yPlus  = 1'b1;
          drive_nxt.yMinus = 1'b1;
        end
        CO_X: begin
          drive_nxt.xPlus  = 1'b1;
          drive_nxt.xMinus = 1'b1;
        end
        CO_Z: begin
          drive_nxt.yPlus  = 1'b1;
          drive_nxt.xMinus = 1'b1;
        end
        default: begin
          drive_nxt = '0;
        end
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg0_r <= CFG0_RST;
      cfg1_r <= CFG1_RST;
    end else begin
      if (wrCfg0) begin
        cfg0_r <= regWdata[CFG0_W-1:0];
      end
      if (wrCfg1) begin
        cfg1_r <= regWdata[CFG1_W-1:0];
      end
    end
  end

  // read data, pen synchroniser and converter clock divider
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_r   <= '0;
      penMeta_r <= 1'b0;
      pen_r     <= 1'b0;
      divCnt_r  <= '0;
    end else begin
      rdata_r   <= regRd ? rdSel : '0;
      penMeta_r <= penDownPin;
      pen_r     <= penMeta_r;
      divCnt_r  <= tick ? 2'h0 : divCnt_r + 2'h1;
    end
  end

  // sequencer state and registered panel drive
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      coord_r <= CO_Y;
      dly_r   <= '0;
      tick_r  <= '0;
      samp_r  <= '0;
      drive_r <= '0;
    end else begin
      state_r <= state_nxt;
      coord_r <= coord_nxt;
      dly_r   <= dly_nxt;
      tick_r  <= tick_nxt;
      samp_r  <= samp_nxt;
      drive_r <= drive_nxt;
    end
  end

  // sample capture and completed-set counter
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sample_r <= '0;
      last_r   <= '0;
      sets_r   <= '0;
    end else begin
      sample_r.valid <= capture;
      if (capture) begin
        sample_r.tag   <= curTag;
        sample_r.value <= adcResult;
        last_r         <= adcResult;
      end
      if (state_r == ST_SENSE && dlyDone && lastCoord) begin
        sets_r <= sets_r + SETS_W'(1);
      end
    end
  end

  assign regRdata = rdata_r;
  assign adcClkEn = tick;
  assign adcStart = (state_r == ST_SAMPLE) && tick && (tick_r == 4'h0);
  assign drive    = drive_r;
  assign sample   = sample_r;

endmodule

`default_nettype wire

// *** verif/tss_panel_model.sv ***
// panel and converter: result follows the driven pair
`timescale 1ns/100ps
`default_nettype none
module tss_panel_model (
  input  wire logic                      mclk,
  input  wire tss_pkg::tss_drive_s       drive,
  output logic     [tss_pkg::RES_W-1:0]  adcResult
);
  import tss_pkg::*;
  logic [3:0]       dv;
  logic [RES_W-1:0] level;
  logic [RES_W-1:0] last_r = '0;
  assign dv = drive;
  assign level = (dv == 4'hc) ? 12'h5a3 : (dv == 4'h3) ? 12'h2c6 : 12'h9e1;
  always @(posedge mclk) if (dv != 4'h0) last_r <= level;
  // an undriven panel floats: show the inverse of the last level
  assign adcResult = (dv != 4'h0) ? level : ~last_r;
endmodule
`default_nettype wire

// *** verif/tss_sequencer_asserts.sv ***
// port-level assertions for the touch scan sequencer
`timescale 1ns/100ps
`default_nettype none
module tss_sequencer_asserts (
  input wire logic                 mclk,
  input wire logic                 rst,
  input wire logic                 adcClkEn,
  input wire logic                 adcStart,
  input wire tss_pkg::tss_drive_s  drive,
  input wire tss_pkg::tss_sample_s sample
);
  import tss_pkg::*;
  wire logic [3:0] dv = drive;
  wire logic       on = |dv;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_drive_pairs: assert property (dv inside {4'h0, 4'hc, 4'h3, 4'h9})
    else $error("illegal panel drive pattern");
  a_no_overlap: assert property (on && $past(on) |-> dv == $past(dv))
    else $error("drive pattern switched without a break");
  a_gap_after: assert property ($fell(on) |=> !on)
    else $error("drive back on without a gap");
  a_settle_first: assert property ($rose(on) |-> !adcStart)
    else $error("conversion started as drivers came on");
  a_start_driven: assert property (adcStart |-> on)
    else $error("conversion started with panel undriven");
  a_start_tick: assert property (adcStart |-> adcClkEn ##1 !adcStart)
    else $error("conversion start off a converter tick");
  a_valid_tick: assert property (sample.valid |-> $past(adcClkEn))
    else $error("sample not after a converter tick");
  a_tag_drive: assert property (sample.valid && on |->
    (sample.tag[1] == (dv == 4'h9)) && ((sample.tag == TAG_X) == (dv == 4'h3)))
    else $error("sample tag does not match drive pair");

  c_z_drive: cover property (dv == 4'h9);
  c_z2_sample: cover property (sample.valid && sample.tag == TAG_Z2);
  c_drive_off: cover property ($fell(on));
endmodule

bind tss_sequencer tss_sequencer_asserts u_chk (.mclk(mclk), .rst(rst), .adcClkEn(adcClkEn),
  .adcStart(adcStart), .drive(drive), .sample(sample));
`default_nettype wire

// *** verif/tss_sequencer_tb_top.sv ***
// self-checking bench for the touch scan sequencer
`timescale 1ns/100ps
`default_nettype none
module tss_sequencer_tb_top;
  import tss_pkg::*;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic              regWr = 1'b0;
  logic              regRd = 1'b0;
  logic              pen = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWdata = '0;
  logic [DATA_W-1:0] regRdata;
  logic [DATA_W-1:0] v;
  logic [RES_W-1:0]  adcResult;
  logic              adcClkEn;
  logic              adcStart;
  tss_drive_s        drive;
  tss_sample_s       sample;
  tss_sample_s       q[$];
  int                onQ[$];
  int                offQ[$];
  int                onCnt = 0;
  int                offCnt = 0;
  int                mismatches = 0;
  int                n_compared = 0;

  tss_sequencer #(.BATCH_STEP_CYC(4)) u_dut (.mclk(mclk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .penDownPin(pen), .adcResult(adcResult), .adcClkEn(adcClkEn),
    .adcStart(adcStart), .drive(drive), .sample(sample));
  tss_panel_model u_panel (.mclk(mclk), .drive(drive), .adcResult(adcResult));

  initial forever #50 mclk = ~mclk;

  always @(posedge mclk) begin
    if (sample.valid === 1'b1) q.push_back(sample);
    if (drive !== 4'h0) begin
      if (offCnt != 0) offQ.push_back(offCnt);
      offCnt = 0;
      onCnt++;
    end else begin
      if (onCnt != 0) onQ.push_back(onCnt);
      onCnt = 0;
      offCnt++;
    end
  end

  task automatic close_out();
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    @(posedge mclk);
    v = regRdata;
  endtask

  task automatic wait_n(input int n);
    for (int i = 0; i < 30000 && q.size() < n; i++) @(posedge mclk);
    if (q.size() < n) begin
      mismatches++;
      close_out();
    end
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 300; i++) begin
      rd(ADDR_STAT);
      if (v[STAT_BUSY_BIT] === 1'b0) return;
    end
    mismatches++;
    close_out();
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rd(ADDR_CFG0);
    chk(v, 32'h1);
    wr(ADDR_CFG0, 32'hffffffff);
    rd(ADDR_CFG0);
    chk(v, 32'h7ff);
    rd(4'h2);
    chk(v, 32'h0);
    wr(ADDR_CFG0, 32'h0);
    wr(ADDR_CFG1, 32'h80);
    rd(ADDR_STAT);
    chk(v[STAT_WARN_BIT], 32'h1);
    // /1, 10-bit, one sample, X-Y-Z, short delays, batch code 1
    wr(ADDR_CFG0, 32'h124);
    wr(ADDR_CFG1, 32'h111);
    pen <= 1'b1;
    wait_n(8);
    pen <= 1'b0;
    wait_idle();
    for (int i = 0; i < 8; i++) chk(q[i].tag, i % 4);
    chk(onQ[0], 22);
    chk(onQ[1], 22);
    chk(onQ[2], 33);
    chk(offQ[1], 32);
    chk(offQ[2], 32);
    chk(offQ[3] > 32, 32'h1);
    rd(ADDR_STAT);
    chk(v[STAT_SETS_LSB +: SETS_W], q.size() / 4);
    // /2, 12-bit, three samples, X-Y only
    q.delete();
    onQ.delete();
    wr(ADDR_CFG0, 32'h001);
    wr(ADDR_CFG1, 32'h184);
    pen <= 1'b1;
    wait_n(6);
    pen <= 1'b0;
    wait_idle();
    for (int i = 0; i < 6; i++) chk({q[i].tag, q[i].value}, {2'(i / 3), i < 3 ? 12'h5a3 : 12'h2c6});
    rd(ADDR_DATA);
    chk(v, 32'h2c6);
    chk(onQ[0] >= 77 && onQ[0] <= 80, 32'h1);
    close_out();
  end
endmodule
`default_nettype wire
